// [bench/wit_watch_interval_timer_test.sv]
// self-checking bench for the watch interval timer
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp); end end
module wit_watch_interval_timer_test
  import wit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sub_clk_in = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic watch_interrupt;
  logic interval_interrupt;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  wit_watch_interval_timer DUT (.core_clk(core_clk), .arst_n(arst_n), .sub_clk_in(sub_clk_in),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .watch_interrupt(watch_interrupt), .interval_interrupt(interval_interrupt));
  always #2.5 core_clk = ~core_clk;
  // subsystem clock free runs at half the core rate: one watch tick every 2 cycles
  always @(posedge core_clk) sub_clk_in <= ~sub_clk_in;
  // ---------------------------------------------------------------
  // bus and wait helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    #1 d = reg_rdata;
  endtask
  // counts cycles up to the next pulse; returns limit when none came
  task automatic wait_sig(input bit w, input int limit, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (!((w ? watch_interrupt : interval_interrupt) === 1'b1) && n < limit);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    rd(WIT_MODE_ADDR, d);
    `CHK(d, 8'h00)
    wr(16'hff40, 8'hff);
    rd(WIT_MODE_ADDR, d);
    `CHK(d, 8'h00)
    rd(16'hff40, d);
    `CHK(d, 8'h00)
    wr(WIT_MODE_ADDR, 8'hfe);
    rd(WIT_MODE_ADDR, d);
    `CHK(d, 8'hfa)
    $display("test regs done");
  endtask
  task automatic t_interval;
    int n;
    for (int c = 0; c < 6; c++) begin
      wr(WIT_MODE_ADDR, 8'h00); // stop before changing selections
      wr(WIT_MODE_ADDR, {1'b1, 3'(c), 4'h1});
      wait_sig(0, 4000, n);
      `CHK(n >= (1 << (5 + c)) - 2 && n <= (1 << (5 + c)) + 8, 1'b1)
      wait_sig(0, 4000, n);
      `CHK(n, 1 << (5 + c))
    end
    wr(WIT_MODE_ADDR, 8'h00);
    wr(WIT_MODE_ADDR, 8'he1);
    wait_sig(0, 4000, n);
    wait_sig(0, 4000, n);
    `CHK(n, 1024)
    wr(WIT_MODE_ADDR, 8'h00);
    wr(WIT_MODE_ADDR, 8'h01);
    wait_sig(0, 3000, n);
    wait_sig(0, 3000, n);
    `CHK(n, 2048)
    $display("test interval done");
  endtask
  task automatic t_short_watch;
    int n;
    wr(WIT_MODE_ADDR, 8'h00);
    wr(WIT_MODE_ADDR, 8'h8b);
    wait_sig(1, 400, n);
    wait_sig(1, 400, n);
    `CHK(n, 64)
    wait_sig(0, 400, n);
    wait_sig(0, 400, n);
    `CHK(n, 32)
    wr(WIT_MODE_ADDR, 8'h89);
    wait_sig(0, 400, n);
    `CHK(n, 30)
    wait_sig(1, 300, n);
    `CHK(n, 300)
    wr(WIT_MODE_ADDR, 8'h00);
    wait_sig(0, 300, n);
    `CHK(n, 300)
    $display("test short watch done");
  endtask
  task automatic t_long_watch;
    int n;
    wr(WIT_MODE_ADDR, 8'h83);
    wait_sig(1, 40000, n);
    `CHK(n >= 33790 && n <= 33800, 1'b1)
    wait_sig(1, 40000, n);
    `CHK(n, 32768)
    $display("test long watch done");
  endtask
  task automatic t_reset;
    int n;
    logic [7:0] d;
    wr(WIT_MODE_ADDR, 8'h8b);
    wait_sig(1, 400, n);
    `CHK(n < 400, 1'b1)
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(WIT_MODE_ADDR, d);
    `CHK(d, 8'h00)
    wait_sig(1, 300, n);
    `CHK(n, 300)
    $display("test reset done");
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ceiling covers the long watch periods with margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      $display("MISMATCH t=%0t run did not complete", $time);
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_interval();
    t_short_watch();
    t_reset();
    t_long_watch();
    finish_test();
  end
endmodule
`default_nettype wire

// [design/wit_pkg.sv]
// constants shared by the watch interval timer files
`default_nettype none
package wit_pkg;
  localparam logic [15:0] WIT_MODE_ADDR = 16'hff41;
  localparam logic [7:0] WIT_MODE_RESET = 8'h00;
  localparam logic [7:0] WIT_MODE_MASK = 8'hfb;
  localparam int WIT_CLK_SEL_BIT = 7;
  localparam int WIT_IVL_SEL_LSB = 4;
  localparam int WIT_IVL_SEL_W = 3;
  localparam int WIT_PERIOD_SEL_BIT = 3;
  localparam int WIT_RUN_BIT = 1;
  localparam int WIT_ENABLE_BIT = 0;
  localparam int WIT_MAIN_DIV_LOG2 = 7;
  localparam int WIT_PRESC_W = 9;
  localparam int WIT_CNT_W = 5;
  localparam int WIT_IVL_BASE_LOG2 = 4;
  localparam int WIT_SHORT_TAP_LOG2 = 5;
  localparam logic [2:0] WIT_IVL_SEL_MAX = 3'h5;
endpackage
`default_nettype wire

// [design/wit_sync_edge.sv]
// two-flop synchroniser with a rising edge pulse
`default_nettype none
module wit_sync_edge (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic rise_pulse
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~prev_q;
endmodule
`default_nettype wire

// [design/wit_watch_interval_timer.sv]
// watch timer with 9-bit prescaler, 5-bit counter and interval tap
// Function
// - The watch clock is the main clock divided by 2^7 when the clock select bit is 0, else the subsystem clock.
// - Interval select codes 0 to 5 pick a prescaler interval of 2^4 to 2^9 watch clocks; codes 6 and 7 are prohibited.
// - The watch period select bit picks 2^14 watch clocks when 0 and 2^5 watch clocks when 1.
// - With the counter run bit at 0 the 5-bit counter is stopped and held clear; at 1 it counts.
// - With the operation enable bit at 0 the timer stops and both prescaler and counter are cleared.
// - Clearing only the run bit restarts the watch count from zero while the prescaler keeps running.
// - With the 2^14 watch period the first watch interrupt after enabling comes one prescaler output late; later ones are exact.
// - Watch and interval interrupts work at the same time, each with its own request.
// - The interval interrupt repeats at the end of every selected interval while operation is enabled.
// - Reset loads the mode register with zero.
`default_nettype none
module wit_watch_interval_timer
  import wit_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sub_clk_in,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic watch_interrupt,
  output logic interval_interrupt
);
  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  wire mode_hit = reg_wr_en && (reg_addr == WIT_MODE_ADDR);
  wire count_clock_select = mode_q[WIT_CLK_SEL_BIT];
  wire [2:0] interval_select = mode_q[WIT_IVL_SEL_LSB +: WIT_IVL_SEL_W];
  wire watch_period_select = mode_q[WIT_PERIOD_SEL_BIT];
  wire counter_run = mode_q[WIT_RUN_BIT];
  wire operation_enable = mode_q[WIT_ENABLE_BIT];

  // mode bits 3..7 are assumed stable while running, so no resync on change
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= WIT_MODE_RESET;
    end else if (mode_hit) begin
      mode_q <= reg_wdata & WIT_MODE_MASK;
    end
  end

  logic [7:0] rdata_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= (reg_addr == WIT_MODE_ADDR) ? mode_q : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // watch clock source
  // ----------------------------------------------------------------
  logic [WIT_MAIN_DIV_LOG2-1:0] div_q;
  logic sub_tick;
  wire div_tick = &div_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  wit_sync_edge u_sub_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(sub_clk_in),
    .rise_pulse(sub_tick)
  );

  wire watch_tick = count_clock_select ? sub_tick : div_tick;

  // ----------------------------------------------------------------
  // prescaler and taps
  // ----------------------------------------------------------------
  logic [WIT_PRESC_W-1:0] presc_q;
  wire presc_step = operation_enable && watch_tick;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= '0;
    end else if (!operation_enable) begin
      presc_q <= '0;
    end else if (watch_tick) begin
      presc_q <= presc_q + 1'b1; // not cleared by the run bit
    end
  end

  // prohibited codes fall back to the longest tap rather than stalling
  wire [3:0] ivl_log2 = (interval_select > WIT_IVL_SEL_MAX) ? 4'(WIT_PRESC_W)
                      : 4'(WIT_IVL_BASE_LOG2) + {1'b0, interval_select};
  wire [WIT_PRESC_W-1:0] ivl_mask = WIT_PRESC_W'((10'h001 << ivl_log2) - 10'h001);
  wire ivl_end = presc_step && ((presc_q & ivl_mask) == ivl_mask);
  wire presc_out = presc_step && (&presc_q);
  wire short_tap = presc_step && (&presc_q[WIT_SHORT_TAP_LOG2-1:0]);

  // ----------------------------------------------------------------
  // 5-bit counter
  // ----------------------------------------------------------------
  logic [WIT_CNT_W-1:0] cnt_q;
  logic armed_q;
  wire cnt_clear = !operation_enable || !counter_run;
  // a wrap in the very cycle that stop is seen would leak a stray watch request
  wire cnt_step = armed_q && presc_out && !cnt_clear;
  wire cnt_wrap = cnt_step && (&cnt_q);

  // the counter only joins on the prescaler output after start: first period is late
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (cnt_clear) begin
      armed_q <= 1'b0;
    end else if (presc_out) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (cnt_clear) begin
      cnt_q <= '0;
    end else if (cnt_step) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  wire watch_evt = watch_period_select ? (short_tap && counter_run) : cnt_wrap;
  logic watch_irq_q;
  logic ivl_irq_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      watch_irq_q <= 1'b0;
      ivl_irq_q <= 1'b0;
    end else begin
      watch_irq_q <= watch_evt;
      ivl_irq_q <= ivl_end;
    end
  end
  assign watch_interrupt = watch_irq_q;
  assign interval_interrupt = ivl_irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // helper: core cycles since the last watch tick, pins the main-clock rate
  // ----------------------------------------------------------------
  logic [7:0] tick_gap_q;
  logic gap_valid_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_gap_q <= 8'h00;
      gap_valid_q <= 1'b0;
    end else if (watch_tick || count_clock_select) begin
      tick_gap_q <= 8'h00;
      gap_valid_q <= watch_tick && !count_clock_select;
    end else begin
      tick_gap_q <= tick_gap_q + 8'h01;
    end
  end

  AST_SOURCE_MAIN: assert property (!count_clock_select && div_tick |-> watch_tick)
    else $error("main divided tick not used as watch clock");
  AST_MAIN_RATE: assert property (!count_clock_select && watch_tick && gap_valid_q
    |-> tick_gap_q == 8'((1 << WIT_MAIN_DIV_LOG2) - 1))
    else $error("main watch tick not every 128 core clocks");
  AST_INTERVAL_TAP: assert property (interval_interrupt && ($past(interval_select) <= WIT_IVL_SEL_MAX)
    |-> ($past(presc_q) & WIT_PRESC_W'((10'h001 << (WIT_IVL_BASE_LOG2 + $past(interval_select))) - 10'h001))
        == WIT_PRESC_W'((10'h001 << (WIT_IVL_BASE_LOG2 + $past(interval_select))) - 10'h001))
    else $error("interval interrupt off its selected tap");
  AST_IVL_FALLBACK: assert property (interval_interrupt && ($past(interval_select) > WIT_IVL_SEL_MAX)
    |-> $past(presc_q) == 9'h1ff)
    else $error("prohibited interval code not on the longest tap");
  AST_LONG_PERIOD: assert property (watch_interrupt && !$past(watch_period_select)
    |-> $past(cnt_q) == 5'h1f && $past(presc_q) == 9'h1ff)
    else $error("long watch interrupt not at counter overflow");
  AST_SHORT_TAP: assert property (watch_interrupt && $past(watch_period_select)
    |-> $past(presc_q[WIT_SHORT_TAP_LOG2-1:0]) == 5'h1f && $past(counter_run))
    else $error("short watch interrupt off the short tap");
  AST_LONG_INDEP: assert property (operation_enable && counter_run && armed_q
    && !watch_period_select && watch_tick && (&presc_q) && (&cnt_q) |=> watch_interrupt)
    else $error("counter overflow gave no watch interrupt");
  AST_RUN_CLEAR: assert property (!counter_run |=> cnt_q == '0)
    else $error("counter not held clear while stopped");
  AST_WATCH_ENABLED: assert property (watch_interrupt |-> $past(operation_enable) && $past(counter_run))
    else $error("watch interrupt while stopped");
  AST_ENABLE_CLEAR: assert property (!operation_enable |=> presc_q == '0 && cnt_q == '0)
    else $error("prescaler or counter not cleared while disabled");
  AST_PRESC_KEEPS: assert property (operation_enable && !counter_run && watch_tick
    |=> presc_q == $past(presc_q) + 1'b1)
    else $error("prescaler stalled by the run bit");
  AST_DISARM: assert property (!operation_enable || !counter_run |=> !armed_q && cnt_q == '0)
    else $error("watch count not restarted from zero");
  AST_FIRST_LATE: assert property (watch_interrupt && !$past(watch_period_select) |-> $past(armed_q))
    else $error("watch interrupt before counter joined");
  AST_IVL_ENABLED: assert property (interval_interrupt |-> $past(operation_enable) && $past(watch_tick))
    else $error("interval interrupt while disabled");
  AST_RESET_MODE: assert property ($rose(arst_n) |-> mode_q == WIT_MODE_RESET)
    else $error("mode register not zero after reset");

  CVR_BOTH: cover property (watch_interrupt && interval_interrupt);
  CVR_SHORT: cover property (watch_interrupt && watch_period_select);
  CVR_SUB: cover property (count_clock_select && interval_interrupt);
  CVR_LONG: cover property (watch_interrupt && !watch_period_select);
  CVR_FALLBACK: cover property (interval_interrupt && (interval_select > WIT_IVL_SEL_MAX));
endmodule
`default_nettype wire
